/* File: verilog/epq_counter.sv */
// Edge timing, pulse accumulators and quadrature decoders for 16 terminals.
// Inputs 0-11 are the universal terminals, 12-15 the control terminals.
// Assumes inputs synchronous to clk_sys and a plain register port.
//
// Summary of operation
// - Edge timing on universal and control terminals
// - Timing result as microseconds or hertz
// - Successive, preceding-terminal and multi-edge spanning intervals
// - Timeout gives NAN result
// - Too-fast signal gives NAN result
// - A leading is clockwise, B leading counterclockwise
// - Universal terminals pair into six decoders
// - Signed net count, up A-lead, down B-lead
// - Net direction plus separate forward/reverse totals
// - Single mode: rising A up, falling A down
// - Double mode: both A edges counted
// - Full mode: every A and B edge counted
// - Own 32-bit accumulator per input, always counting
// - Accumulator advances exactly one per pulse
// - Scan start captures then clears accumulators
// - Accumulator wraps and flags overflow
// - Frequency is captured count over scan interval
// - Switch inputs debounced to one count
`timescale 1ns/100ps
module epq_counter
  import epq_pkg::*;
(
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [N_IN-1:0] term_in, // Terminal levels
  input wire logic [8:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic scan_tick // One-cycle pulse at each scan start
);
  // ==========================================================
  // Control registers
  logic [9:0] ctrl;
  logic [31:0] scan_ms;
  logic [31:0] tmo;
  logic [7:0] span_edges;
  logic [N_IN-1:0] deb_en;
  wire wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
  wire wr_stat = reg_wr && reg_addr == OFS_STAT;
  wire wr_fcmd = reg_wr && reg_addr == OFS_FCMD;
  wire scan_en = ctrl[CTRL_SCAN_EN];
  wire [1:0] qmode = ctrl[CTRL_QMODE_LSB +: 2];
  wire arm = wr_ctrl && reg_wdata[CTRL_ARM];

  // Register writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= RST_CTRL;
      scan_ms <= RST_SCAN_MS;
      tmo <= RST_TMO;
      span_edges <= RST_SPAN;
      deb_en <= RST_DEB;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) ctrl <= reg_wdata[9:0];
      if (reg_addr == OFS_SCAN_MS) scan_ms <= reg_wdata;
      if (reg_addr == OFS_TMO) tmo <= reg_wdata;
      if (reg_addr == OFS_SPAN) span_edges <= reg_wdata[7:0];
      if (reg_addr == OFS_DEB) deb_en <= reg_wdata[N_IN-1:0];
    end
  end

  // ==========================================================
  // Time base: microsecond and millisecond ticks
  logic [6:0] us_div;
  logic [9:0] ms_div;
  wire us_tick = us_div == 7'(CYC_PER_US - 1);
  wire ms_tick = us_tick && ms_div == 10'(US_PER_MS - 1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      us_div <= 7'h00;
      ms_div <= 10'h000;
    end else begin
      us_div <= us_tick ? 7'h00 : us_div + 7'h01;
      if (us_tick) ms_div <= ms_tick ? 10'h000 : ms_div + 10'h001;
    end
  end

  // ==========================================================
  // Synchroniser, debounce and edge detection
  logic [N_IN-1:0] sync1;
  logic [N_IN-1:0] sync2;
  logic [N_IN-1:0] filt;
  logic [N_IN-1:0] filt_q;
  logic [9:0] deb_cnt [N_IN];
  wire [N_IN-1:0] rise = filt & ~filt_q;

  // Two flops per input, first one read only by the second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= term_in;
      sync2 <= sync1;
    end
  end

  // Debounced inputs follow only after a steady millisecond
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      filt <= '0;
      filt_q <= '0;
      for (int i = 0; i < N_IN; i++) deb_cnt[i] <= 10'h000;
    end else begin
      filt_q <= filt;
      for (int i = 0; i < N_IN; i++) begin
        if (!deb_en[i] || sync2[i] == filt[i]) begin
          filt[i] <= sync2[i];
          deb_cnt[i] <= 10'h000;
        end else if (us_tick) begin
          if (deb_cnt[i] == 10'(DEB_US - 1)) filt[i] <= sync2[i];
          deb_cnt[i] <= deb_cnt[i] + 10'h001;
        end
      end
    end
  end

  // ==========================================================
  // Scan timer
  logic [31:0] scan_ms_cnt;
  logic [31:0] scan_cnt;
  wire scan_due = scan_en && ms_tick && scan_ms_cnt >= scan_ms - 32'h1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scan_ms_cnt <= 32'h0;
      scan_tick <= 1'b0;
      scan_cnt <= 32'h0;
    end else begin
      scan_tick <= scan_due;
      if (!scan_en || scan_due) scan_ms_cnt <= 32'h0;
      else if (ms_tick) scan_ms_cnt <= scan_ms_cnt + 32'h1;
      if (scan_tick) scan_cnt <= scan_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Pulse accumulators
  logic [31:0] acc [N_IN];
  logic [31:0] cap [N_IN];
  logic [N_IN-1:0] ovf;
  logic [N_IN-1:0] ovf_set;
  wire [N_IN-1:0] ovf_clr = wr_stat ? reg_wdata[STAT_OVF_LSB +: N_IN] : '0;

  always_comb begin
    for (int i = 0; i < N_IN; i++) ovf_set[i] = !scan_tick && rise[i] && &acc[i];
  end

  // Count rising edges; capture and restart at scan start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ovf <= '0;
      for (int i = 0; i < N_IN; i++) begin
        acc[i] <= 32'h0;
        cap[i] <= 32'h0;
      end
    end else begin
      ovf <= (ovf & ~ovf_clr) | ovf_set;
      for (int i = 0; i < N_IN; i++) begin
        if (scan_tick) begin
          cap[i] <= acc[i];
          acc[i] <= {31'h0, rise[i]};
        end else begin
          acc[i] <= acc[i] + {31'h0, rise[i]};
        end
      end
    end
  end

  // ==========================================================
  // Quadrature decoders on adjacent universal pairs
  logic signed [31:0] qnet [N_PAIR];
  logic [31:0] qfwd [N_PAIR];
  logic [31:0] qrev [N_PAIR];
  logic [N_PAIR-1:0] qdir;
  logic [1:0] qstep [N_PAIR];

  always_comb begin
    for (int p = 0; p < N_PAIR; p++) begin
      qstep[p] = epq_quad_step(qmode, filt[2*p], filt[2*p+1],
                               filt_q[2*p], filt_q[2*p+1]);
    end
  end

  // Net count, direction (1 = clockwise) and per-direction totals
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      qdir <= '0;
      for (int p = 0; p < N_PAIR; p++) begin
        qnet[p] <= 32'sh0;
        qfwd[p] <= 32'h0;
        qrev[p] <= 32'h0;
      end
    end else begin
      for (int p = 0; p < N_PAIR; p++) begin
        if (qstep[p][1]) begin
          qnet[p] <= qnet[p] + 32'sh1;
          qfwd[p] <= qfwd[p] + 32'h1;
          qdir[p] <= 1'b1;
        end else if (qstep[p][0]) begin
          qnet[p] <= qnet[p] - 32'sh1;
          qrev[p] <= qrev[p] + 32'h1;
          qdir[p] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Edge timing unit
  epq_tstate_t tstate;
  epq_tmode_t tmode;
  logic [3:0] tch;
  logic [7:0] span_left;
  logic [31:0] t_el;
  logic [31:0] t_meas;
  logic [31:0] tres;
  logic tdone;
  logic tnan;
  wire [3:0] start_ch = (tmode == TM_PREV) ? tch - 4'h1 : tch;
  wire t_to = t_el >= tmo;
  wire t_fin = rise[tch] && !(tmode == TM_SPAN && span_left > 8'h01);
  wire t_fast = t_meas < MIN_RES_US;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tstate <= TS_IDLE;
      tmode <= TM_SUCC;
      tch <= 4'h0;
      span_left <= 8'h00;
      t_el <= 32'h0;
      t_meas <= 32'h0;
      tres <= 32'h0;
      tdone <= 1'b0;
      tnan <= 1'b0;
    end else if (arm) begin
      tstate <= TS_WAIT;
      tmode <= epq_tmode_t'(reg_wdata[CTRL_TMODE_LSB +: 2]);
      tch <= reg_wdata[CTRL_TCH_LSB +: 4];
      span_left <= span_edges;
      t_el <= 32'h0;
      tdone <= 1'b0;
      tnan <= 1'b0;
    end else begin
      if (us_tick) t_el <= t_el + 32'h1;
      if (us_tick) t_meas <= t_meas + 32'h1;
      case (tstate)
        TS_IDLE: begin
        end
        TS_WAIT: begin
          if (t_to) begin
            tstate <= TS_IDLE;
            tres <= NAN_VAL;
            tnan <= 1'b1;
            tdone <= 1'b1;
          end else if (rise[start_ch]) begin
            tstate <= TS_RUN;
            t_meas <= 32'h0;
          end
        end
        TS_RUN: begin
          if (t_to) begin
            tstate <= TS_IDLE;
            tres <= NAN_VAL;
            tnan <= 1'b1;
            tdone <= 1'b1;
          end else if (t_fin) begin
            tstate <= TS_IDLE;
            tres <= t_fast ? NAN_VAL : t_meas;
            tnan <= t_fast;
            tdone <= 1'b1;
          end else if (rise[tch]) begin
            span_left <= span_left - 8'h01;
          end
        end
        default: tstate <= TS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Frequency unit: source 0 is the timing result, 1-16 an accumulator
  logic [4:0] fsrc;
  logic fbad;
  logic [31:0] fres;
  logic fbusy;
  logic fdone;
  logic [31:0] fquo;
  logic ffault;
  wire f_time = reg_wdata[4:0] == 5'h00;
  wire [3:0] f_idx = 4'(reg_wdata[4:0] - 5'h01);
  wire [47:0] f_dvd = f_time ? FREQ_US_PER_S : 48'({16'h0, cap[f_idx]} * FREQ_MS_PER_S);
  wire [31:0] f_dvs = f_time ? tres : scan_ms;
  wire f_bad_now = f_time ? (tnan || !tdone) : reg_wdata[4:0] > 5'(N_IN);

  epq_div u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(wr_fcmd),
    .dividend(f_dvd),
    .divisor(f_dvs),
    .busy(fbusy),
    .done(fdone),
    .quotient(fquo),
    .fault(ffault)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fsrc <= 5'h00;
      fbad <= 1'b0;
      fres <= 32'h0;
    end else begin
      if (wr_fcmd && !fbusy) fsrc <= reg_wdata[4:0];
      if (wr_fcmd && !fbusy) fbad <= f_bad_now;
      if (fdone) fres <= (fbad || ffault) ? NAN_VAL : fquo;
    end
  end

  // ==========================================================
  // Read path
  wire q_hit = (reg_addr & QMASK) == OFS_QBASE && reg_addr[6:4] < 3'(N_PAIR);
  wire a_hit = (reg_addr & AMASK) == OFS_ABASE;
  wire [2:0] q_idx = q_hit ? reg_addr[6:4] : 3'h0;
  wire [31:0] q_word = reg_addr[3:2] == 2'h0 ? qnet[q_idx] :
                       reg_addr[3:2] == 2'h1 ? qfwd[q_idx] :
                       reg_addr[3:2] == 2'h2 ? qrev[q_idx] : {31'h0, qdir[q_idx]};
  wire [31:0] stat_word = {ovf, 13'h0, tnan, tdone, tstate != TS_IDLE};
  wire [31:0] rd_mux =
    reg_addr == OFS_CTRL ? {22'h0, ctrl} :
    reg_addr == OFS_SCAN_MS ? scan_ms :
    reg_addr == OFS_TMO ? tmo :
    reg_addr == OFS_SPAN ? {24'h0, span_edges} :
    reg_addr == OFS_DEB ? {16'h0, deb_en} :
    reg_addr == OFS_STAT ? stat_word :
    reg_addr == OFS_TRES ? tres :
    reg_addr == OFS_SCNT ? scan_cnt :
    reg_addr == OFS_FCMD ? {fbusy, 26'h0, fsrc} :
    reg_addr == OFS_FRES ? fres :
    q_hit ? q_word :
    a_hit ? cap[reg_addr[5:2]] : 32'h0;

  // Read data stand for one cycle only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_SCAN_CAPTURE: assert property (scan_tick |=>
    cap[3] == $past(acc[3]) && acc[3] <= 32'h1)
    else $error("scan start did not capture and clear");
  AST_ACC_STEP: assert property (!scan_tick |=> acc[1] - $past(acc[1]) <= 32'h1)
    else $error("accumulator moved by more than one");
  AST_OVF_FLAG: assert property (ovf_set[2] |=> ovf[2] && acc[2] == 32'h0)
    else $error("overflow not wrapped or flagged");
  AST_QUAD_INVALID: assert property ((filt[0] != filt_q[0]) &&
    (filt[1] != filt_q[1]) |=> $stable(qnet[0]) && $stable(qfwd[0]) && $stable(qrev[0]))
    else $error("invalid quadrature transition counted");
  AST_QUAD_FULL_UP: assert property ((qmode == QM_FULL && !filt_q[2] && !filt_q[3] &&
    filt[2] && !filt[3]) |=> qnet[1] == $past(qnet[1]) + 32'sh1 && qdir[1])
    else $error("A-leading step not counted up");
  AST_QUAD_SINGLE_FALL: assert property ((qmode == QM_SINGLE && filt_q[4] && filt_q[5] &&
    filt[4] && !filt[5]) |=> $stable(qnet[2]))
    else $error("single mode counted a B edge");
  AST_TIMEOUT_NAN: assert property ((tstate != TS_IDLE && t_to && !arm) |=>
    tres == NAN_VAL && tnan && tdone && tstate == TS_IDLE)
    else $error("timeout did not give NAN");
  AST_FAST_NAN: assert property ((tstate == TS_RUN && !t_to && !arm && t_fin && t_fast)
    |=> tres == NAN_VAL && tnan)
    else $error("too-fast signal not flagged NAN");
  AST_SYNC_PATH: assert property ((!deb_en[0] && term_in[0] && !filt[0])
    |-> ##3 (filt[0] || $past(deb_en[0])))
    else $error("synchronised input not followed in three cycles");
  AST_SCAN_PULSE: assert property (scan_tick |=> !scan_tick [*8])
    else $error("scan start pulse repeated");

  COV_SCAN: cover property (scan_tick && acc[0] != 32'h0);
  COV_QUAD_DOWN: cover property (qmode == QM_DOUBLE && qstep[0] == 2'b01);
  COV_TIMING_OK: cover property (tstate == TS_RUN ##1 tdone && !tnan);
  COV_FREQ: cover property (fdone && !ffault);
endmodule

/* File: verilog/epq_pkg.sv */
// Constants, register map and types for the edge, pulse and quadrature counter.
// Assumes one 125 MHz system clock and synchronous terminal inputs.
package epq_pkg;
  // ==========================================================
  // Sizes and timing
  localparam int N_IN = 16;
  localparam int N_PAIR = 6;
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int DEB_US = 1000;
  localparam int DIV_STEPS = 48;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [8:0] OFS_CTRL = 9'h000;
  localparam logic [8:0] OFS_SCAN_MS = 9'h004;
  localparam logic [8:0] OFS_TMO = 9'h008;
  localparam logic [8:0] OFS_SPAN = 9'h00C;
  localparam logic [8:0] OFS_DEB = 9'h010;
  localparam logic [8:0] OFS_STAT = 9'h014;
  localparam logic [8:0] OFS_TRES = 9'h018;
  localparam logic [8:0] OFS_SCNT = 9'h01C;
  localparam logic [8:0] OFS_FCMD = 9'h020;
  localparam logic [8:0] OFS_FRES = 9'h024;
  localparam logic [8:0] OFS_QBASE = 9'h080;
  localparam logic [8:0] QMASK = 9'h180;
  localparam logic [8:0] OFS_ABASE = 9'h100;
  localparam logic [8:0] AMASK = 9'h1C0;

  // ==========================================================
  // Field positions
  localparam int CTRL_SCAN_EN = 0;
  localparam int CTRL_QMODE_LSB = 1;
  localparam int CTRL_TMODE_LSB = 3;
  localparam int CTRL_TCH_LSB = 5;
  localparam int CTRL_ARM = 10;
  localparam int STAT_OVF_LSB = 16;

  // ==========================================================
  // Reset values and result constants
  localparam logic [9:0] RST_CTRL = 10'h000;
  localparam logic [31:0] RST_SCAN_MS = 32'h000003E8;
  localparam logic [31:0] RST_TMO = 32'h000F4240;
  localparam logic [7:0] RST_SPAN = 8'h02;
  localparam logic [15:0] RST_DEB = 16'hF000;
  localparam logic [31:0] NAN_VAL = 32'h7FC00000;
  localparam logic [31:0] MIN_RES_US = 32'h00000001;
  localparam logic [47:0] FREQ_US_PER_S = 48'h0000000F4240;
  localparam logic [47:0] FREQ_MS_PER_S = 48'h0000000003E8;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {QM_SINGLE, QM_DOUBLE, QM_FULL} epq_qmode_t;
  typedef enum logic [1:0] {TM_SUCC, TM_PREV, TM_SPAN} epq_tmode_t;
  typedef enum logic [1:0] {TS_IDLE, TS_WAIT, TS_RUN} epq_tstate_t;

  // Quadrature step for one pair: returns {up, down}
  function automatic logic [1:0] epq_quad_step(input logic [1:0] mode, input logic a,
                                               input logic b, input logic pa, input logic pb);
    logic ea;
    logic eb;
    logic lead_a;
    logic cnt;
    ea = a ^ pa;
    eb = b ^ pb;
    lead_a = ea ? (a != b) : (a == b);
    case (mode)
      QM_SINGLE: cnt = ea && !eb && (lead_a ? a : !a);
      QM_DOUBLE: cnt = ea && !eb;
      QM_FULL: cnt = ea ^ eb;
      default: cnt = 1'b0;
    endcase
    return {cnt && lead_a, cnt && !lead_a};
  endfunction
endpackage

/* File: verilog/epq_div.sv */
// Serial unsigned divider, 48-bit dividend by 32-bit divisor.
// Assumes a start pulse with operands valid in the same cycle.
`timescale 1ns/100ps
module epq_div
  import epq_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic start, // Start pulse, ignored while busy
  input wire logic [47:0] dividend, // Dividend
  input wire logic [31:0] divisor, // Divisor
  output logic busy, // Division in progress
  output logic done, // One-cycle pulse at the end
  output logic [31:0] quotient, // Low quotient word
  output logic fault // Divide by zero or quotient too wide
);
  // ==========================================================
  // Datapath
  logic [47:0] q;
  logic [32:0] rem;
  logic [31:0] dvs;
  logic [5:0] steps;
  logic dz;
  wire [32:0] shifted = {rem[31:0], q[47]};
  wire fits = shifted >= {1'b0, dvs};

  assign quotient = q[31:0];
  assign fault = dz || (|q[47:32]);

  // One quotient bit per clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= 48'h0;
      rem <= 33'h0;
      dvs <= 32'h0;
      steps <= 6'h0;
      dz <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        q <= dividend;
        rem <= 33'h0;
        dvs <= divisor;
        dz <= divisor == 32'h0;
        steps <= 6'(DIV_STEPS);
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? shifted - {1'b0, dvs} : shifted;
        q <= {q[46:0], fits};
        steps <= steps - 6'h01;
        busy <= steps != 6'h01;
        done <= steps == 6'h01;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_DIV_LATENCY: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (start && !busy) |-> ##49 done)
    else $error("divider did not finish in 49 cycles");
endmodule

/* File: tb/epq_encoder.sv */
// Encoder model for the six quadrature pairs on terminals 0-11.
// Assumes step and jump are one-cycle pulses from the bench.
`timescale 1ns/100ps
module epq_encoder (
  input wire logic clk_sys, // System clock
  input wire logic step, // Move one quarter cycle
  input wire logic jump, // Move both lines at once
  input wire logic [2:0] pair, // Pair to move
  input wire logic cw, // Direction, 1 when A leads
  output logic [11:0] ab // Line levels, A on even bits
);
  // ====================
  // Phase state
  logic [1:0] phase [6];
  initial for (int i = 0; i < 6; i++) phase[i] = 2'h0;
  // Phase moves by one per step, by two on a jump
  always @(posedge clk_sys) begin
    if (step) phase[pair] <= cw ? phase[pair] + 2'h1 : phase[pair] - 2'h1;
    else if (jump) phase[pair] <= phase[pair] + 2'h2;
  end
  // Gray code lines, A ahead of B when turning clockwise
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      ab[2*i] = phase[i][1] ^ phase[i][0];
      ab[2*i+1] = phase[i][1];
    end
  end
endmodule

/* File: tb/test_epq_counter.sv */
// Testbench for the edge, pulse and quadrature counter.
// Assumes the encoder model on terminals 0-11 and bench pulses on 12-15.
`timescale 1ns/100ps
module test_epq_counter
  import epq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic scan_tick;
  logic step = 1'b0;
  logic jump = 1'b0;
  logic [2:0] pair = 3'h0;
  logic cw = 1'b0;
  logic [11:0] ab;
  logic [3:0] ctl = 4'h0; // Control terminals carry timing and counting traffic
  logic [31:0] rv;
  int num_errors = 0;
  int checks_done = 0;
  int i;
  logic [8:0] ra [8] = '{OFS_CTRL, OFS_SCAN_MS, OFS_TMO, OFS_SPAN, OFS_DEB, OFS_SCNT,
                         9'h13C, 9'h028};
  logic [31:0] rx [8] = '{32'h00000000, 32'h000003E8, 32'h000F4240, 32'h00000002,
                          32'h0000F000, 32'h00000000, 32'h00000000, 32'h00000000};

  // ====================
  // Clock, encoder and design
  always #4 clk_sys = ~clk_sys;
  epq_encoder epq_encoder_i (.clk_sys(clk_sys), .step(step), .jump(jump), .pair(pair),
    .cw(cw), .ab(ab));
  epq_counter epq_counter_i (.clk_sys(clk_sys), .reset_n(reset_n), .term_in({ctl, ab}),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scan_tick(scan_tick));

  // ====================
  // Report and compare
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ====================
  // Register port cycles
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic chk(input logic [8:0] a, input logic [31:0] exp);
    rd(a);
    check(rv, exp);
  endtask
  // Poll the timing done flag with a bound
  task automatic wait_done();
    for (int n = 0; n < 2000; n++) begin
      rd(OFS_STAT);
      if (rv[1] === 1'b1) return;
    end
    num_errors++;
    finish_test();
  endtask
  // Return just before a microsecond tick edge, so timed pulses start at a known phase
  task automatic align();
    for (int n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      #1;
      if (epq_counter_i.us_tick === 1'b1) return;
    end
    num_errors++;
    finish_test();
  endtask

  // ====================
  // Terminal stimulus
  task automatic enc(input logic [2:0] p, input logic dir, input int n, input logic bad);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys);
      pair <= p;
      cw <= dir;
      step <= !bad;
      jump <= bad;
      @(posedge clk_sys);
      step <= 1'b0;
      jump <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task automatic pulse(input int b, input int hi, input int lo, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys);
      ctl[b] <= 1'b1;
      repeat (hi) @(posedge clk_sys);
      ctl[b] <= 1'b0;
      repeat (lo - 1) @(posedge clk_sys);
    end
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    wr(9'h028, 32'hFFFFFFFF);
    for (i = 0; i < 8; i++) chk(ra[i], rx[i]);
    $display("test reset done");
    wr(OFS_CTRL, 32'h00000004);
    enc(3'h0, 1'b1, 4, 1'b0);
    chk(OFS_QBASE, 32'h00000004);
    chk(9'h084, 32'h00000004);
    chk(9'h08C, 32'h00000001);
    enc(3'h0, 1'b0, 6, 1'b0);
    chk(OFS_QBASE, 32'hFFFFFFFE);
    chk(9'h088, 32'h00000006);
    chk(9'h08C, 32'h00000000);
    enc(3'h0, 1'b0, 1, 1'b1);
    chk(OFS_QBASE, 32'hFFFFFFFE);
    wr(OFS_CTRL, 32'h00000002);
    enc(3'h1, 1'b1, 4, 1'b0);
    chk(9'h090, 32'h00000002);
    wr(OFS_CTRL, 32'h00000000);
    enc(3'h2, 1'b1, 4, 1'b0);
    chk(9'h0A0, 32'h00000001);
    enc(3'h2, 1'b0, 4, 1'b0);
    chk(9'h0A8, 32'h00000001);
    chk(9'h0A0, 32'h00000000);
    $display("test quadrature done");
    wr(OFS_DEB, 32'h00004000);
    wr(OFS_CTRL, 32'h00000580);
    align();
    pulse(0, 625, 625, 2);
    wait_done();
    chk(OFS_TRES, 32'h0000000A);
    wr(OFS_FCMD, 32'h00000000);
    repeat (60) @(posedge clk_sys);
    chk(OFS_FRES, 32'h000186A0);
    wr(OFS_CTRL, 32'h00000580);
    align();
    pulse(0, 2, 2, 2);
    wait_done();
    chk(OFS_TRES, NAN_VAL);
    chk(OFS_STAT, 32'h00000006);
    wr(OFS_CTRL, 32'h000005A8);
    align();
    pulse(0, 10, 10, 1);
    repeat (355) @(posedge clk_sys);
    pulse(1, 10, 10, 1);
    wait_done();
    chk(OFS_TRES, 32'h00000003);
    wr(OFS_CTRL, 32'h00000590);
    align();
    pulse(0, 250, 250, 3);
    wait_done();
    chk(OFS_TRES, 32'h00000008);
    wr(OFS_TMO, 32'h00000005);
    wr(OFS_CTRL, 32'h000005A0);
    wait_done();
    chk(OFS_TRES, NAN_VAL);
    $display("test timing done");
    pulse(3, 3, 3, 3);
    pulse(2, 3, 3, 5);
    wr(OFS_SCAN_MS, 32'h00000001);
    wr(OFS_CTRL, 32'h00000001);
    i = 0;
    while (scan_tick !== 1'b1 && i < 130000) begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (i >= 130000) begin
      num_errors++;
      finish_test();
    end
    chk(9'h13C, 32'h00000003);
    chk(9'h138, 32'h00000000);
    chk(OFS_SCNT, 32'h00000001);
    wr(OFS_FCMD, 32'h00000010);
    repeat (60) @(posedge clk_sys);
    chk(OFS_FRES, 32'h00000BB8);
    $display("test scan done");
    finish_test();
  end
endmodule
